// File: hdl/tmr_defs.svh
// Register indices, field positions and encodings of the three timers
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH
// ==========================================================
// Register indices (byte address is four times the index)
`define TMR_IDX_IRQ_EN 8'hc2
`define TMR_IDX_IRQ_PENDING_FLAGS 8'hc3
`define TMR_IDX_T0_COUNT 8'hc8
`define TMR_IDX_T0_CTL 8'hc9
`define TMR_IDX_T1_COUNT 8'hca
`define TMR_IDX_T1_CTL 8'hcb
`define TMR_IDX_T2_LOW 8'hcc
`define TMR_IDX_T2_HIGH 8'hcd
`define TMR_IDX_T2_CTL 8'hce
`define TMR_ADDR_W 12
// ==========================================================
// Control fields
`define TMR_CTL_RUN 7
`define TMR_CTL_NORELOAD 6
`define TMR_CTL_GATE 5
`define TMR_CTL_CS_HI 2
`define TMR_CTL_MASK8 8'hc7
`define TMR_CTL_MASK16 8'he7
// ==========================================================
// Clock select codes
`define TMR_CS_DIV1 3'h0
`define TMR_CS_DIV4 3'h1
`define TMR_CS_DIV16 3'h2
`define TMR_CS_DIV64 3'h3
`define TMR_CS_SUB 3'h4
`define TMR_CS_PIN 3'h7
`define TMR_PRE_W 6
`define TMR_PRE_DIV4 6'h03
`define TMR_PRE_DIV16 6'h0f
`define TMR_PRE_DIV64 6'h3f
// ==========================================================
// Pending flag bits
`define TMR_IRQ_T0 3
`define TMR_IRQ_T1 5
`define TMR_IRQ_T2 6
`define TMR_IRQ_MASK 8'h68
// ==========================================================
// Reset values and bus answers
`define TMR_RST_BYTE 8'h00
`define TMR_RST_WORD 16'h0000
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2
`endif

// File: hdl/tmr_pkg.sv
// Types shared by the timer block
`include "tmr_defs.svh"
package tmr_pkg;
  typedef struct packed {
    logic [7:0] ctl0_r;
    logic [7:0] ctl1_r;
    logic [7:0] ctl2_r;
    logic [7:0] rl0_r;
    logic [7:0] rl1_r;
    logic [15:0] rl2_r;
    logic [7:0] irq_en_r;
    logic [7:0] irq_pend_r;
    logic [`TMR_PRE_W-1:0] pre_r;
    logic sub_s1_r;
    logic sub_s2_r;
    logic sub_d_r;
    logic pin_s1_r;
    logic pin_s2_r;
    logic pin_d_r;
    logic aw_full_r;
    logic [`TMR_ADDR_W-1:0] aw_addr_r;
    logic w_full_r;
    logic [7:0] w_data_r;
    logic w_strb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
  } tmr_state_t;
endpackage : tmr_pkg

// File: hdl/count_if.sv
// Carrier between the timer control logic and one down counter
`timescale 1ns/100ps
`default_nettype none
interface count_if #(parameter int W = 8);
  logic load;
  logic tick;
  logic reload_en;
  logic [W-1:0] reload_val;
  logic [W-1:0] count;
  logic underflow;
  modport ctrl (output load, output tick, output reload_en, output reload_val,
                input count, input underflow);
  modport cnt (input load, input tick, input reload_en, input reload_val,
               output count, output underflow);
endinterface : count_if
`default_nettype wire

// File: hdl/down_counter.sv
// One down counter with preload and optional automatic reload
`timescale 1ns/100ps
`default_nettype none
module down_counter #(
  parameter int W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  count_if.cnt bus
);
  typedef struct packed {
    logic [W-1:0] count_r;
  } cnt_state_t;

  cnt_state_t st_r;
  cnt_state_t st_nxt;

  // Load wins over a tick in the same cycle
  assign bus.underflow = bus.tick && !bus.load && (st_r.count_r == '0);
  assign bus.count = st_r.count_r;

  always_comb begin
    st_nxt = st_r;
    if (bus.load) begin
      st_nxt.count_r = bus.reload_val;
    end else if (bus.tick) begin
      if (st_r.count_r == '0) begin
        // Without reload it rests at zero; the run bit is dropped upstream
        if (bus.reload_en) begin
          st_nxt.count_r = bus.reload_val;
        end
      end else begin
        st_nxt.count_r = st_r.count_r - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end
endmodule : down_counter
`default_nettype wire

// File: hdl/triple_timers.sv
// Three down-count timers with AXI4-Lite register access
`timescale 1ns/100ps
`default_nettype none
`include "tmr_defs.svh"
// Notes on behaviour
// - First timer: 8-bit, underflows every count+1 ticks
// - Second timer: 8-bit, underflows every count+1 ticks
// - 8-bit timers: run write preloads; clear stops
// - Third timer: run write loads; clear stops
// - Reload-disable one stops reload; zero reloads
// - 8-bit select: divide 1/4/16/64, top bit sub-oscillator
// - Third select: dividers, 100 sub, 111 pin edges
// - Qualify set: count only while pin high
// - Qualify clear: count regardless of pin level
// - Select 111 overrides the pin qualify bit
// - Underflow sets own pending flag; enable gates request
// - Writing one clears only those pending bits
module triple_timers (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic sub_osc_clock,
  input wire logic external_count_pin,
  input wire logic [`TMR_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`TMR_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq_request
);
  tmr_pkg::tmr_state_t st_r;
  tmr_pkg::tmr_state_t st_nxt;

  count_if #(.W(8)) c0 ();
  count_if #(.W(8)) c1 ();
  count_if #(.W(16)) c2 ();

  down_counter #(.W(8)) u_cnt0 (.aclk(aclk), .aresetn(aresetn), .ce(ce), .bus(c0));
  down_counter #(.W(8)) u_cnt1 (.aclk(aclk), .aresetn(aresetn), .ce(ce), .bus(c1));
  down_counter #(.W(16)) u_cnt2 (.aclk(aclk), .aresetn(aresetn), .ce(ce), .bus(c2));

  // ==========================================================
  // Register decode
  function automatic logic idx_mapped(input logic [`TMR_ADDR_W-1:0] a);
    logic [7:0] i;
    i = a[9:2];
    idx_mapped = (a[`TMR_ADDR_W-1:10] == '0) &&
                 (i == `TMR_IDX_IRQ_EN || i == `TMR_IDX_IRQ_PENDING_FLAGS ||
                  (i >= `TMR_IDX_T0_COUNT && i <= `TMR_IDX_T2_CTL));
  endfunction : idx_mapped

  logic wr_go;
  logic [7:0] wr_idx;
  logic [7:0] wr_byte;
  logic wr_en;
  logic rd_go;
  logic [7:0] rd_idx;

  assign s_axi_awready = ce && !st_r.aw_full_r && !st_r.bvalid_r;
  assign s_axi_wready = ce && !st_r.w_full_r && !st_r.bvalid_r;
  assign s_axi_arready = ce && !st_r.rvalid_r;
  assign s_axi_bvalid = st_r.bvalid_r;
  assign s_axi_bresp = st_r.bresp_r;
  assign s_axi_rvalid = st_r.rvalid_r;
  assign s_axi_rdata = st_r.rdata_r;
  assign s_axi_rresp = st_r.rresp_r;

  assign wr_go = ce && st_r.aw_full_r && st_r.w_full_r && !st_r.bvalid_r;
  assign wr_idx = st_r.aw_addr_r[9:2];
  assign wr_byte = st_r.w_data_r;
  // Only byte lane 0 carries data; other lanes are ignored
  assign wr_en = wr_go && st_r.w_strb_r && idx_mapped(st_r.aw_addr_r);
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign rd_idx = s_axi_araddr[9:2];

  // ==========================================================
  // Input clock selection
  logic sub_rise;
  logic pin_rise;
  logic pin_high;
  logic [2:0] cs0;
  logic [2:0] cs1;
  logic [2:0] cs2;
  logic gate_ok;

  assign sub_rise = st_r.sub_s2_r && !st_r.sub_d_r;
  assign pin_rise = st_r.pin_s2_r && !st_r.pin_d_r;
  assign pin_high = st_r.pin_s2_r;
  assign cs0 = st_r.ctl0_r[`TMR_CTL_CS_HI:0];
  assign cs1 = st_r.ctl1_r[`TMR_CTL_CS_HI:0];
  assign cs2 = st_r.ctl2_r[`TMR_CTL_CS_HI:0];

  function automatic logic pre_tick(input logic [1:0] code,
                                    input logic [`TMR_PRE_W-1:0] pre);
    case (code)
      2'h0: pre_tick = 1'b1;
      2'h1: pre_tick = (pre & `TMR_PRE_DIV4) == `TMR_PRE_DIV4;
      2'h2: pre_tick = (pre & `TMR_PRE_DIV16) == `TMR_PRE_DIV16;
      2'h3: pre_tick = pre == `TMR_PRE_DIV64;
      default: pre_tick = 1'b0;
    endcase
  endfunction : pre_tick

  function automatic logic sel8(input logic [2:0] cs, input logic [`TMR_PRE_W-1:0] pre,
                                input logic sub);
    // Top bit alone picks the sub-oscillator
    sel8 = cs[2] ? sub : pre_tick(cs[1:0], pre);
  endfunction : sel8

  logic sel2;
  always_comb begin
    case (cs2)
      `TMR_CS_DIV1, `TMR_CS_DIV4, `TMR_CS_DIV16, `TMR_CS_DIV64: begin
        sel2 = pre_tick(cs2[1:0], st_r.pre_r);
      end
      `TMR_CS_SUB: begin
        sel2 = sub_rise;
      end
      `TMR_CS_PIN: begin
        sel2 = pin_rise;
      end
      // Codes 101 and 110 give no clock
      default: begin
        sel2 = 1'b0;
      end
    endcase
  end

  // Pin qualify is overridden when the pin itself is the clock
  assign gate_ok = !st_r.ctl2_r[`TMR_CTL_GATE] || (cs2 == `TMR_CS_PIN) || pin_high;

  // ==========================================================
  // Counter control
  assign c0.tick = ce && st_r.ctl0_r[`TMR_CTL_RUN] && sel8(cs0, st_r.pre_r, sub_rise);
  assign c1.tick = ce && st_r.ctl1_r[`TMR_CTL_RUN] && sel8(cs1, st_r.pre_r, sub_rise);
  assign c2.tick = ce && st_r.ctl2_r[`TMR_CTL_RUN] && gate_ok && sel2;
  assign c0.load = wr_en && wr_idx == `TMR_IDX_T0_CTL && wr_byte[`TMR_CTL_RUN];
  assign c1.load = wr_en && wr_idx == `TMR_IDX_T1_CTL && wr_byte[`TMR_CTL_RUN];
  assign c2.load = wr_en && wr_idx == `TMR_IDX_T2_CTL && wr_byte[`TMR_CTL_RUN];
  assign c0.reload_en = !st_r.ctl0_r[`TMR_CTL_NORELOAD];
  assign c1.reload_en = !st_r.ctl1_r[`TMR_CTL_NORELOAD];
  assign c2.reload_en = !st_r.ctl2_r[`TMR_CTL_NORELOAD];
  assign c0.reload_val = st_r.rl0_r;
  assign c1.reload_val = st_r.rl1_r;
  assign c2.reload_val = st_r.rl2_r;

  assign irq_request = |(st_r.irq_pend_r & st_r.irq_en_r);

  // ==========================================================
  // Next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.pre_r = st_r.pre_r + {{(`TMR_PRE_W-1){1'b0}}, 1'b1};
    // Synchroniser stage one feeds only stage two
    st_nxt.sub_s1_r = sub_osc_clock;
    st_nxt.sub_s2_r = st_r.sub_s1_r;
    st_nxt.sub_d_r = st_r.sub_s2_r;
    st_nxt.pin_s1_r = external_count_pin;
    st_nxt.pin_s2_r = st_r.pin_s1_r;
    st_nxt.pin_d_r = st_r.pin_s2_r;

    // Stop after an underflow that does not reload
    if (c0.underflow && !c0.reload_en) begin
      st_nxt.ctl0_r[`TMR_CTL_RUN] = 1'b0;
    end
    if (c1.underflow && !c1.reload_en) begin
      st_nxt.ctl1_r[`TMR_CTL_RUN] = 1'b0;
    end
    if (c2.underflow && !c2.reload_en) begin
      st_nxt.ctl2_r[`TMR_CTL_RUN] = 1'b0;
    end

    // Write channels
    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.aw_full_r = 1'b1;
      st_nxt.aw_addr_r = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.w_full_r = 1'b1;
      st_nxt.w_data_r = s_axi_wdata[7:0];
      st_nxt.w_strb_r = s_axi_wstrb[0];
    end
    if (wr_go) begin
      st_nxt.aw_full_r = 1'b0;
      st_nxt.w_full_r = 1'b0;
      st_nxt.bvalid_r = 1'b1;
      st_nxt.bresp_r = idx_mapped(st_r.aw_addr_r) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
    end else if (st_r.bvalid_r && s_axi_bready && ce) begin
      st_nxt.bvalid_r = 1'b0;
    end

    // A software write to a control register wins over the hardware stop
    if (wr_en) begin
      case (wr_idx)
        `TMR_IDX_T0_COUNT: st_nxt.rl0_r = wr_byte;
        `TMR_IDX_T0_CTL: st_nxt.ctl0_r = wr_byte & `TMR_CTL_MASK8;
        `TMR_IDX_T1_COUNT: st_nxt.rl1_r = wr_byte;
        `TMR_IDX_T1_CTL: st_nxt.ctl1_r = wr_byte & `TMR_CTL_MASK8;
        `TMR_IDX_T2_LOW: st_nxt.rl2_r[7:0] = wr_byte;
        `TMR_IDX_T2_HIGH: st_nxt.rl2_r[15:8] = wr_byte;
        `TMR_IDX_T2_CTL: st_nxt.ctl2_r = wr_byte & `TMR_CTL_MASK16;
        `TMR_IDX_IRQ_EN: st_nxt.irq_en_r = wr_byte & `TMR_IRQ_MASK;
        default: st_nxt.irq_en_r = st_nxt.irq_en_r;
      endcase
    end

    // Pending flags: a set in the clearing cycle survives
    if (wr_en && wr_idx == `TMR_IDX_IRQ_PENDING_FLAGS) begin
      st_nxt.irq_pend_r = st_r.irq_pend_r & ~wr_byte;
    end
    st_nxt.irq_pend_r[`TMR_IRQ_T0] = st_nxt.irq_pend_r[`TMR_IRQ_T0] | c0.underflow;
    st_nxt.irq_pend_r[`TMR_IRQ_T1] = st_nxt.irq_pend_r[`TMR_IRQ_T1] | c1.underflow;
    st_nxt.irq_pend_r[`TMR_IRQ_T2] = st_nxt.irq_pend_r[`TMR_IRQ_T2] | c2.underflow;

    // Read channel; count registers show the live counters
    if (rd_go) begin
      st_nxt.rvalid_r = 1'b1;
      st_nxt.rresp_r = idx_mapped(s_axi_araddr) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      st_nxt.rdata_r = '0;
      if (idx_mapped(s_axi_araddr)) begin
        case (rd_idx)
          `TMR_IDX_T0_COUNT: st_nxt.rdata_r[7:0] = c0.count;
          `TMR_IDX_T0_CTL: st_nxt.rdata_r[7:0] = st_r.ctl0_r;
          `TMR_IDX_T1_COUNT: st_nxt.rdata_r[7:0] = c1.count;
          `TMR_IDX_T1_CTL: st_nxt.rdata_r[7:0] = st_r.ctl1_r;
          `TMR_IDX_T2_LOW: st_nxt.rdata_r[7:0] = c2.count[7:0];
          `TMR_IDX_T2_HIGH: st_nxt.rdata_r[7:0] = c2.count[15:8];
          `TMR_IDX_T2_CTL: st_nxt.rdata_r[7:0] = st_r.ctl2_r;
          `TMR_IDX_IRQ_EN: st_nxt.rdata_r[7:0] = st_r.irq_en_r;
          `TMR_IDX_IRQ_PENDING_FLAGS: st_nxt.rdata_r[7:0] = st_r.irq_pend_r;
          default: st_nxt.rdata_r = '0;
        endcase
      end
    end else if (st_r.rvalid_r && s_axi_rready && ce) begin
      st_nxt.rvalid_r = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_t0_reload_value: assert property (
    c0.underflow && c0.reload_en |=> c0.count == $past(st_r.rl0_r) || $past(c0.load))
    else $error("Timer 0 did not reload after underflow");
  chk_t1_count_step: assert property (
    c1.tick && !c1.load && c1.count != 8'h00 |=> c1.count == $past(c1.count) - 8'h01)
    else $error("Timer 1 did not count down by one");
  chk_t0_run_preload: assert property (
    c0.load |=> c0.count == $past(st_r.rl0_r) && st_r.ctl0_r[`TMR_CTL_RUN])
    else $error("Timer 0 run write did not preload and start");
  chk_t2_run_load: assert property (
    c2.load |=> c2.count == $past(st_r.rl2_r) && st_r.ctl2_r[`TMR_CTL_RUN])
    else $error("Timer 2 run write did not load and start");
  chk_noreload_stops: assert property (
    c1.underflow && !c1.reload_en && !c1.load && !wr_en |=> !st_r.ctl1_r[`TMR_CTL_RUN])
    else $error("Timer 1 kept running with reload disabled");
  chk_sub_select: assert property (
    ce && st_r.ctl0_r[`TMR_CTL_RUN] && cs0[2] |-> c0.tick == sub_rise)
    else $error("Timer 0 sub-oscillator select wrong");
  chk_pin_edges: assert property (
    ce && st_r.ctl2_r[`TMR_CTL_RUN] && cs2 == `TMR_CS_PIN |-> c2.tick == pin_rise)
    else $error("Timer 2 does not follow pin edges");
  chk_gate_holds: assert property (
    st_r.ctl2_r[`TMR_CTL_GATE] && cs2 != `TMR_CS_PIN && !pin_high |-> !c2.tick)
    else $error("Timer 2 counted with gate pin low");
  chk_nogate_runs: assert property (
    ce && st_r.ctl2_r[`TMR_CTL_RUN] && !st_r.ctl2_r[`TMR_CTL_GATE] &&
    cs2 == `TMR_CS_DIV1 |-> c2.tick)
    else $error("Timer 2 stalled without gating");
  chk_pend_set: assert property (
    c0.underflow |=> st_r.irq_pend_r[`TMR_IRQ_T0])
    else $error("Timer 0 underflow left flag clear");
  chk_clear_only_ones: assert property (
    st_r.irq_pend_r[`TMR_IRQ_T2] && !(wr_en && wr_idx == `TMR_IDX_IRQ_PENDING_FLAGS &&
    wr_byte[`TMR_IRQ_T2]) |=> st_r.irq_pend_r[`TMR_IRQ_T2])
    else $error("Timer 2 flag cleared without a one written");
  chk_t2_wrap: assert property (
    c2.underflow && c2.reload_en |=> c2.count == $past(st_r.rl2_r) || $past(c2.load))
    else $error("Timer 2 16-bit reload wrong");

  // Selection, stop and flag checks across all three timers
  chk_t0_div1_tick: assert property (
    ce && st_r.ctl0_r[`TMR_CTL_RUN] && cs0 == `TMR_CS_DIV1 |-> c0.tick)
    else $error("Timer 0 missed a tick at divide by one");
  chk_t1_sub_select: assert property (
    ce && st_r.ctl1_r[`TMR_CTL_RUN] && cs1[2] |-> c1.tick == sub_rise)
    else $error("Timer 1 sub-oscillator select wrong");
  chk_t0_stopped: assert property (
    !st_r.ctl0_r[`TMR_CTL_RUN] |-> !c0.tick)
    else $error("Timer 0 ticked while stopped");
  chk_t1_stopped: assert property (
    !st_r.ctl1_r[`TMR_CTL_RUN] |-> !c1.tick)
    else $error("Timer 1 ticked while stopped");
  chk_t2_stopped: assert property (
    !st_r.ctl2_r[`TMR_CTL_RUN] |-> !c2.tick)
    else $error("Timer 2 ticked while stopped");
  chk_gate_override: assert property (
    ce && st_r.ctl2_r[`TMR_CTL_RUN] && st_r.ctl2_r[`TMR_CTL_GATE] &&
    cs2 == `TMR_CS_PIN |-> c2.tick == pin_rise)
    else $error("Timer 2 pin clock blocked by qualify bit");
  chk_t2_dead_codes: assert property (
    cs2[2] && (cs2[1] ^ cs2[0]) |-> !c2.tick)
    else $error("Timer 2 ticked on an unused select code");
  chk_t2_sub_select: assert property (
    ce && st_r.ctl2_r[`TMR_CTL_RUN] && !st_r.ctl2_r[`TMR_CTL_GATE] &&
    cs2 == `TMR_CS_SUB |-> c2.tick == sub_rise)
    else $error("Timer 2 sub-oscillator select wrong");
  chk_t1_pend_set: assert property (
    c1.underflow |=> st_r.irq_pend_r[`TMR_IRQ_T1])
    else $error("Timer 1 underflow left flag clear");
  chk_t2_pend_set: assert property (
    c2.underflow |=> st_r.irq_pend_r[`TMR_IRQ_T2])
    else $error("Timer 2 underflow left flag clear");
  chk_t0_rest_zero: assert property (
    c0.underflow && !c0.reload_en && !wr_en |=>
    c0.count == 8'h00 && !st_r.ctl0_r[`TMR_CTL_RUN])
    else $error("Timer 0 did not rest after one-shot underflow");
  chk_t2_rest_zero: assert property (
    c2.underflow && !c2.reload_en && !wr_en |=>
    c2.count == 16'h0000 && !st_r.ctl2_r[`TMR_CTL_RUN])
    else $error("Timer 2 did not rest after one-shot underflow");
  chk_t2_count_step: assert property (
    c2.tick && !c2.load && c2.count != 16'h0000 |=> c2.count == $past(c2.count) - 16'h0001)
    else $error("Timer 2 did not count down by one");
endmodule : triple_timers
`default_nettype wire

// File: dv/triple_down_count_timers_test.sv
// Self-checking bench for the three down-count timers
`timescale 1ns/100ps
`default_nettype none
`include "tmr_defs.svh"
module triple_down_count_timers_test;
  typedef struct {
    logic [31:0] data;
    logic [1:0] resp;
    logic is_read;
  } note_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic sub_osc_clock = 1'b0;
  logic external_count_pin = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [11:0] s_axi_araddr = 12'h000;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic irq_request;
  int mismatches = 0;
  int check_count = 0;
  int seed = 44;
  note_t notes[$];
  localparam logic [1:0] OK = `AXI_RESP_OKAY;
  localparam logic [11:0] PEND = {2'b00, 8'hc3, 2'b00};

  triple_timers dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .sub_osc_clock(sub_osc_clock),
    .external_count_pin(external_count_pin), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq_request(irq_request));

  // ==========================================================
  // Clock, verdict and watchdog
  initial begin
    forever #12.5 aclk = ~aclk;
  end

  task automatic stop_test;
    if (mismatches == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (60000) @(posedge aclk);
    mismatches++;
    stop_test();
  end

  // ==========================================================
  // Compare tasks and the output watcher
  task automatic compare_data(input string what, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : compare_data

  task automatic compare_resp(input string what, input logic [1:0] e, input logic [1:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : compare_resp

  always @(posedge aclk) begin
    note_t n;
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
      n = notes.pop_front();
      compare_resp("bresp", n.resp, s_axi_bresp);
    end
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      n = notes.pop_front();
      compare_resp("rresp", n.resp, s_axi_rresp);
      compare_data("rdata", n.data, s_axi_rdata);
    end
  end

  // ==========================================================
  // Bus master tasks; the answer is awaited, the watchdog ends a hang
  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask : cyc

  function automatic logic [11:0] ba(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction : ba

  task automatic axi_write(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    notes.push_back('{32'h0, er, 1'b0});
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    notes.push_back('{ed, er, 1'b1});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask : axi_read

  task automatic pend_is(input logic [7:0] v);
    axi_read(PEND, {24'h0, v}, OK);
  endtask : pend_is

  // Edges spaced wide so the two-stage synchronisers never miss one
  task automatic pulse(input int k, input logic on_sub);
    repeat (k) begin
      @(posedge aclk);
      if (on_sub) sub_osc_clock <= 1'b1;
      else external_count_pin <= 1'b1;
      cyc(4);
      if (on_sub) sub_osc_clock <= 1'b0;
      else external_count_pin <= 1'b0;
      cyc(4);
    end
  endtask : pulse

  // ==========================================================
  // Main sequence
  initial begin
    int d;
    int n;
    logic [7:0] v;
    cyc(12);
    aresetn <= 1'b1;
    for (int i = 8'hc2; i <= 8'hce; i++) begin
      if (i < 8'hc4 || i > 8'hc7) axi_read(ba(i[7:0]), 32'h0, OK);
    end
    axi_read(12'h004, 32'h0, `AXI_RESP_SLVERR);
    axi_write(12'h004, 8'hff, `AXI_RESP_SLVERR);
    axi_write(ba(`TMR_IDX_T0_CTL), 8'h7f, OK);
    axi_read(ba(`TMR_IDX_T0_CTL), 32'h47, OK);
    axi_write(ba(`TMR_IDX_T2_CTL), 8'h7f, OK);
    axi_read(ba(`TMR_IDX_T2_CTL), 32'h67, OK);
    // One-shot period of 16 ticks at every divider
    for (int c = 0; c < 4; c++) begin
      d = 1 << (2 * c);
      axi_write(ba(`TMR_IDX_T0_COUNT), 8'h0f, OK);
      axi_write(ba(`TMR_IDX_T0_CTL), 8'hc0 | c[7:0], OK);
      if (c > 0) begin
        cyc(15 * d / 2);
        pend_is(8'h00);
      end
      cyc(16 * d + 10);
      pend_is(8'h08);
      axi_read(ba(`TMR_IDX_T0_COUNT), 32'h0, OK);
      axi_read(ba(`TMR_IDX_T0_CTL), 32'h40 | c, OK);
      axi_write(PEND, 8'h08, OK);
    end
    // Second timer with reload keeps underflowing
    n = 40 + ($random(seed) & 15);
    axi_write(ba(`TMR_IDX_T1_COUNT), n[7:0], OK);
    axi_write(ba(`TMR_IDX_T1_CTL), 8'h80, OK);
    cyc(n + 11);
    pend_is(8'h20);
    axi_write(PEND, 8'h20, OK);
    pend_is(8'h00);
    cyc(n + 1);
    pend_is(8'h20);
    axi_read(ba(`TMR_IDX_T1_CTL), 32'h80, OK);
    axi_write(ba(`TMR_IDX_T1_CTL), 8'h00, OK);
    axi_write(ba(`TMR_IDX_T0_COUNT), 8'h01, OK);
    axi_write(ba(`TMR_IDX_T0_CTL), 8'hc0, OK);
    cyc(6);
    axi_write(PEND, 8'h20, OK);
    pend_is(8'h08);
    axi_write(ba(`TMR_IDX_IRQ_EN), 8'h08, OK);
    compare_resp("irq_request", 2'h1, {1'b0, irq_request});
    axi_write(ba(`TMR_IDX_IRQ_EN), 8'h20, OK);
    compare_resp("irq_request", 2'h0, {1'b0, irq_request});
    axi_write(PEND, 8'h08, OK);
    // Third timer spans both bytes
    axi_write(ba(`TMR_IDX_T2_LOW), 8'h2c, OK);
    axi_write(ba(`TMR_IDX_T2_HIGH), 8'h01, OK);
    axi_write(ba(`TMR_IDX_T2_CTL), 8'hc0, OK);
    cyc(250);
    pend_is(8'h00);
    cyc(80);
    pend_is(8'h40);
    axi_read(ba(`TMR_IDX_T2_HIGH), 32'h0, OK);
    axi_write(PEND, 8'h40, OK);
    // Pin qualify: held while low, runs while high
    axi_write(ba(`TMR_IDX_T2_LOW), 8'h05, OK);
    axi_write(ba(`TMR_IDX_T2_HIGH), 8'h00, OK);
    axi_write(ba(`TMR_IDX_T2_CTL), 8'he0, OK);
    cyc(20);
    axi_read(ba(`TMR_IDX_T2_LOW), 32'h05, OK);
    external_count_pin <= 1'b1;
    cyc(20);
    pend_is(8'h40);
    external_count_pin <= 1'b0;
    axi_write(PEND, 8'h40, OK);
    axi_write(ba(`TMR_IDX_T2_CTL), 8'hc0, OK);
    cyc(20);
    pend_is(8'h40);
    axi_write(PEND, 8'h40, OK);
    // Edge counting on the pin, qualify bit set but overridden
    axi_write(ba(`TMR_IDX_T2_LOW), 8'h02, OK);
    axi_write(ba(`TMR_IDX_T2_CTL), 8'he7, OK);
    cyc(20);
    pulse(2, 1'b0);
    pend_is(8'h00);
    pulse(1, 1'b0);
    cyc(6);
    pend_is(8'h40);
    axi_write(PEND, 8'h40, OK);
    // Sub-oscillator on both timers; low select bits ignored on the first
    v = 8'hc4 | 8'($random(seed) & 3);
    axi_write(ba(`TMR_IDX_T0_COUNT), 8'h02, OK);
    axi_write(ba(`TMR_IDX_T0_CTL), v, OK);
    axi_write(ba(`TMR_IDX_T2_LOW), 8'h01, OK);
    axi_write(ba(`TMR_IDX_T2_CTL), 8'hc4, OK);
    cyc(30);
    pend_is(8'h00);
    pulse(2, 1'b1);
    cyc(6);
    pend_is(8'h40);
    pulse(1, 1'b1);
    cyc(6);
    pend_is(8'h48);
    // Clock enable low for longer than the period: no underflow may appear
    axi_write(ba(`TMR_IDX_T1_COUNT), 8'h20, OK);
    axi_write(ba(`TMR_IDX_T1_CTL), 8'hc0, OK);
    ce <= 1'b0;
    cyc(100);
    ce <= 1'b1;
    pend_is(8'h48);
    stop_test();
  end
endmodule : triple_down_count_timers_test
`default_nettype wire
